// [hdl/supply_pkg.sv]
`default_nettype none
package supply_pkg;
  // Timebase
  localparam int CLK_NS = 8;
  localparam int CLK_MHZ = 125;
  localparam int BLANK_US = 110;
  localparam int BLANK_CYC_DEF = (BLANK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SW_KHZ_DEF = 300;
  localparam int SW_DIV_DEF = (CLK_MHZ * 1000) / SW_KHZ_DEF;
  localparam int BOOT_SW_CYC = 15;
  // Short-circuit timer for a 0.1 uF soft-start capacitor
  localparam int SC_START_US = 46000;
  localparam int SC_RUN_US = 130000;
  localparam int SC_START_CYC_DEF = SC_START_US * CLK_MHZ;
  localparam int SC_RUN_CYC_DEF = SC_RUN_US * CLK_MHZ;
  // Voltage code decode, millivolts
  localparam int MV_W = 11;
  localparam logic [10:0] VID_TOP_MV = 11'h06ac;
  localparam logic [10:0] VID_STEP_MV = 11'h0010;
  // Register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_DEEP_OFS = 8'h0c;
  localparam logic [7:0] REG_BOOT_MV = 8'h10;
  localparam logic [7:0] REG_DEEPER_MV = 8'h14;
  localparam logic [7:0] REG_TARGET = 8'h18;
  // Reset values
  localparam logic [7:0] DEEP_OFS_RST = 8'h0d;
  localparam logic [10:0] BOOT_MV_RST = 11'h04b0;
  localparam logic [10:0] DEEPER_MV_RST = 11'h02ee;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_PG_FALL = 0;
  localparam int IRQ_LATCH = 1;
  localparam int IRQ_BOOT = 2;
  localparam int IRQ_RESTART = 3;
  // Status bits
  localparam int ST_PG = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BOOT = 2;
  localparam int ST_BLANK = 3;
  localparam int ST_MODE = 4;
  localparam int ST_PIN = 6;
  localparam int ST_LIMIT = 7;
  localparam int ST_ARMED = 8;
  typedef enum logic [1:0] {
    MODE_BOOT = 2'b00,
    MODE_VID = 2'b01,
    MODE_DEEP = 2'b10,
    MODE_DEEPER = 2'b11
  } mode_t;
endpackage : supply_pkg
`default_nettype wire

// [hdl/pin_sync.sv]
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;
  // A bit changes only once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end
  assign q_out = q_ff;
endmodule : pin_sync
`default_nettype wire

// [hdl/axil_port.sv]
`default_nettype none
module axil_port #(
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic have_aw_ff, nxt_have_aw, have_w_ff, nxt_have_w;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [AW-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;

  always_comb begin
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_have_aw = have_aw_ff;
    nxt_have_w = have_w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    wr_en = have_aw_ff && have_w_ff && !bvalid_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awready = 1'b0;
      nxt_have_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wready = 1'b0;
      nxt_have_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_en) begin
      nxt_have_aw = 1'b0;
      nxt_have_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_ok ? 2'h0 : 2'h2;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    rd_en = s_axi_arvalid && arready_ff;
    if (rd_en) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_ok ? rd_data : 32'h0000_0000;
      nxt_rresp = rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      have_aw_ff <= 1'b0;
      have_w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      have_aw_ff <= nxt_have_aw;
      have_w_ff <= nxt_have_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign rd_addr = s_axi_araddr;
endmodule : axil_port
`default_nettype wire

// [hdl/supply_target_power_good_out_mask.sv]
`default_nettype none
module supply_target_power_good_out_mask import supply_pkg::*; #(
  parameter int BLANK_CYC = BLANK_CYC_DEF,
  parameter int SW_DIV = SW_DIV_DEF,
  parameter int SC_START_CYC = SC_START_CYC_DEF,
  parameter int SC_RUN_CYC = SC_RUN_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] voltage_code,
  input wire logic stop_clock_request_n,
  input wire logic deeper_sleep_select,
  input wire logic chipset_power_good,
  input wire logic run_ss_on,
  input wire logic run_ss_armed,
  input wire logic vout_in_window,
  input wire logic vout_below_70,
  input wire logic latch_defeat,
  input wire logic power_good_out_i,
  output logic power_good_out_o,
  output logic power_good_out_oe_n,
  output logic boot_done,
  output logic regulator_enable,
  output logic current_limit_active,
  output logic [1:0] target_mode,
  output logic [MV_W-1:0] target_mv,
  output logic irq
);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int SCW = $clog2(SC_RUN_CYC + 1);
  localparam int DW = $clog2(SW_DIV + 1);
  localparam logic [BW-1:0] BLANK_MAX = BW'(BLANK_CYC);
  localparam logic [DW-1:0] DIV_MAX = DW'(SW_DIV - 1);
  localparam logic [3:0] BOOT_MAX = 4'(BOOT_SW_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  logic [14:0] pins;
  logic [5:0] code_s;
  logic stp_n_s, dpr_s, chip_pg_s, run_s, armed_s, in_win_s, low70_s;
  logic defeat_s, pin_s;

  pin_sync #(.W(15)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d_in({power_good_out_i, latch_defeat, vout_below_70, vout_in_window,
           run_ss_armed, run_ss_on, chipset_power_good, deeper_sleep_select,
           stop_clock_request_n, voltage_code}),
    .q_out(pins)
  );
  assign code_s = pins[5:0];
  assign stp_n_s = pins[6];
  assign dpr_s = pins[7];
  assign chip_pg_s = pins[8];
  assign run_s = pins[9];
  assign armed_s = pins[10];
  assign in_win_s = pins[11];
  assign low70_s = pins[12];
  assign defeat_s = pins[13];
  assign pin_s = pins[14];

  //////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic wr_en, wr_ok, rd_en, rd_ok;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  axil_port #(.AW(8)) u_axil (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Target selection
  logic [5:0] code_ff;
  mode_t mode_ff, nxt_mode;
  logic [MV_W-1:0] target_ff, nxt_target, vid_mv, boot_mv_ff, deeper_mv_ff;
  logic [18:0] ofs_prod;
  logic [7:0] deep_ofs_ff;
  logic boot_done_ff, ev_change;

  always_comb begin
    vid_mv = VID_TOP_MV - ({5'h00, code_s} * VID_STEP_MV);
    ofs_prod = {8'h00, vid_mv} * {11'h000, deep_ofs_ff};
    if (!boot_done_ff) begin
      nxt_mode = MODE_BOOT;
    end else if (dpr_s) begin
      nxt_mode = MODE_DEEPER;
    end else if (!stp_n_s) begin
      nxt_mode = MODE_DEEP;
    end else begin
      nxt_mode = MODE_VID;
    end
    unique case (nxt_mode)
      MODE_BOOT: nxt_target = boot_mv_ff;
      MODE_VID: nxt_target = vid_mv;
      MODE_DEEP: nxt_target = vid_mv - ofs_prod[18:8];
      MODE_DEEPER: nxt_target = deeper_mv_ff;
    endcase
    ev_change = (code_s != code_ff) || (nxt_mode != mode_ff);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= 6'h00;
      mode_ff <= MODE_BOOT;
      target_ff <= BOOT_MV_RST;
    end else begin
      code_ff <= code_s;
      mode_ff <= nxt_mode;
      target_ff <= nxt_target;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-good masking
  logic [BW-1:0] blank_ff, nxt_blank, fault_ff, nxt_fault;
  logic armed_seen_ff, nxt_armed_seen, oe_n_ff, nxt_oe_n, latched_ff;

  always_comb begin
    nxt_armed_seen = run_s && (armed_seen_ff || armed_s);
    if (ev_change) begin
      nxt_blank = BLANK_MAX;
    end else if (blank_ff != '0) begin
      nxt_blank = blank_ff - 1'b1;
    end else begin
      nxt_blank = blank_ff;
    end
    if (in_win_s) begin
      nxt_fault = '0;
    end else if (fault_ff != BLANK_MAX) begin
      nxt_fault = fault_ff + 1'b1;
    end else begin
      nxt_fault = fault_ff;
    end
    if (!run_s) begin
      nxt_oe_n = 1'b0;
    end else if (!armed_seen_ff) begin
      nxt_oe_n = 1'b0;
    end else if (latched_ff) begin
      nxt_oe_n = 1'b0;
    end else if (blank_ff != '0) begin
      nxt_oe_n = 1'b1;
    end else begin
      nxt_oe_n = (fault_ff != BLANK_MAX);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_ff <= '0;
      fault_ff <= '0;
      armed_seen_ff <= 1'b0;
      oe_n_ff <= 1'b0;
    end else begin
      blank_ff <= nxt_blank;
      fault_ff <= nxt_fault;
      armed_seen_ff <= nxt_armed_seen;
      oe_n_ff <= nxt_oe_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot delay on the switching timebase
  logic [DW-1:0] div_ff, nxt_div;
  logic [3:0] boot_cnt_ff, nxt_boot_cnt;
  logic nxt_boot_done, sw_tick;

  always_comb begin
    sw_tick = (div_ff == DIV_MAX);
    nxt_div = sw_tick ? '0 : div_ff + 1'b1;
    nxt_boot_cnt = boot_cnt_ff;
    nxt_boot_done = boot_done_ff;
    if (!run_s) begin
      nxt_boot_cnt = 4'h0;
      nxt_boot_done = 1'b0;
    end else if (!(oe_n_ff && chip_pg_s) && !boot_done_ff) begin
      nxt_boot_cnt = 4'h0;
    end else if (sw_tick && !boot_done_ff) begin
      nxt_boot_cnt = boot_cnt_ff + 1'b1;
      nxt_boot_done = (boot_cnt_ff == BOOT_MAX - 4'h1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      boot_cnt_ff <= 4'h0;
      boot_done_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      boot_cnt_ff <= nxt_boot_cnt;
      boot_done_ff <= nxt_boot_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Short-circuit latchoff
  logic [SCW-1:0] sc_ff, nxt_sc, sc_lim;
  logic nxt_latched, en_ff, nxt_en, limit_ff, nxt_limit;

  always_comb begin
    sc_lim = boot_done_ff ? SCW'(SC_RUN_CYC) : SCW'(SC_START_CYC);
    nxt_sc = '0;
    nxt_latched = latched_ff;
    if (!run_s) begin
      nxt_latched = 1'b0;
    end else if (armed_seen_ff && low70_s && !defeat_s && !latched_ff) begin
      nxt_sc = sc_ff + 1'b1;
      nxt_latched = (nxt_sc >= sc_lim);
    end
    nxt_en = run_s && !nxt_latched;
    nxt_limit = run_s && low70_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_ff <= '0;
      latched_ff <= 1'b0;
      en_ff <= 1'b0;
      limit_ff <= 1'b0;
    end else begin
      sc_ff <= nxt_sc;
      latched_ff <= nxt_latched;
      en_ff <= nxt_en;
      limit_ff <= nxt_limit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt
  logic [IRQ_W-1:0] irq_st_ff, nxt_irq_st, mask_ff, nxt_mask, ev;
  logic [7:0] nxt_deep_ofs;
  logic [MV_W-1:0] nxt_boot_mv, nxt_deeper_mv;
  logic irq_ff, nxt_irq;
  logic [31:0] status;

  always_comb begin
    ev = '0;
    ev[IRQ_PG_FALL] = oe_n_ff && !nxt_oe_n;
    ev[IRQ_LATCH] = !latched_ff && nxt_latched;
    ev[IRQ_BOOT] = !boot_done_ff && nxt_boot_done;
    ev[IRQ_RESTART] = ev_change && (blank_ff != '0);
    status = 32'h0000_0000;
    status[ST_PG] = oe_n_ff;
    status[ST_LATCH] = latched_ff;
    status[ST_BOOT] = boot_done_ff;
    status[ST_BLANK] = (blank_ff != '0);
    status[ST_MODE +: 2] = mode_ff;
    status[ST_PIN] = pin_s;
    status[ST_LIMIT] = limit_ff;
    status[ST_ARMED] = armed_seen_ff;
    rd_ok = 1'b1;
    unique case (rd_addr)
      REG_STATUS: rd_data = status;
      REG_IRQ: rd_data = {28'h000_0000, irq_st_ff};
      REG_MASK: rd_data = {28'h000_0000, mask_ff};
      REG_DEEP_OFS: rd_data = {24'h00_0000, deep_ofs_ff};
      REG_BOOT_MV: rd_data = {21'h00_0000, boot_mv_ff};
      REG_DEEPER_MV: rd_data = {21'h00_0000, deeper_mv_ff};
      REG_TARGET: rd_data = {21'h00_0000, target_ff};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    wr_ok = (wr_addr == REG_MASK) || (wr_addr == REG_DEEP_OFS) ||
            (wr_addr == REG_BOOT_MV) || (wr_addr == REG_DEEPER_MV) ||
            (wr_addr == REG_STATUS) || (wr_addr == REG_IRQ) || (wr_addr == REG_TARGET);
    nxt_mask = mask_ff;
    nxt_deep_ofs = deep_ofs_ff;
    nxt_boot_mv = boot_mv_ff;
    nxt_deeper_mv = deeper_mv_ff;
    if (wr_en && wr_strb[0]) begin
      if (wr_addr == REG_MASK) nxt_mask = wr_data[IRQ_W-1:0];
      if (wr_addr == REG_DEEP_OFS) nxt_deep_ofs = wr_data[7:0];
      if (wr_addr == REG_BOOT_MV) nxt_boot_mv[7:0] = wr_data[7:0];
      if (wr_addr == REG_DEEPER_MV) nxt_deeper_mv[7:0] = wr_data[7:0];
    end
    if (wr_en && wr_strb[1]) begin
      if (wr_addr == REG_BOOT_MV) nxt_boot_mv[10:8] = wr_data[10:8];
      if (wr_addr == REG_DEEPER_MV) nxt_deeper_mv[10:8] = wr_data[10:8];
    end
    // Read clears, a same-cycle event still lands
    nxt_irq_st = ((rd_en && rd_addr == REG_IRQ) ? '0 : irq_st_ff) | ev;
    nxt_irq = |(nxt_irq_st & nxt_mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_ff <= '0;
      mask_ff <= MASK_RST;
      deep_ofs_ff <= DEEP_OFS_RST;
      boot_mv_ff <= BOOT_MV_RST;
      deeper_mv_ff <= DEEPER_MV_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      mask_ff <= nxt_mask;
      deep_ofs_ff <= nxt_deep_ofs;
      boot_mv_ff <= nxt_boot_mv;
      deeper_mv_ff <= nxt_deeper_mv;
      irq_ff <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_n = oe_n_ff;
  assign boot_done = boot_done_ff;
  assign regulator_enable = en_ff;
  assign current_limit_active = limit_ff;
  assign target_mode = mode_ff;
  assign target_mv = target_ff;
  assign irq = irq_ff;
endmodule : supply_target_power_good_out_mask
`default_nettype wire

// [verif/supply_checker_props.sv]
`default_nettype none
module supply_checker import supply_pkg::*; #(
  parameter int BLANK_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [5:0] voltage_code,
  input wire logic stop_clock_request_n,
  input wire logic deeper_sleep_select,
  input wire logic run_ss_on,
  input wire logic vout_in_window,
  input wire logic vout_below_70,
  input wire logic power_good_out_o,
  input wire logic power_good_out_oe_n,
  input wire logic boot_done,
  input wire logic regulator_enable,
  input wire logic current_limit_active,
  input wire logic [1:0] target_mode,
  input wire logic [MV_W-1:0] target_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Out-of-window run length with no code, state or boot change in it
  logic [8:0] seen_ff;
  logic [8:0] nxt_seen;
  int unsigned out_run_ff;
  int unsigned nxt_out_run;
  always_comb begin
    nxt_seen = {voltage_code, stop_clock_request_n, deeper_sleep_select, boot_done};
    nxt_out_run = out_run_ff + 1;
    if (vout_in_window || nxt_seen != seen_ff) begin
      nxt_out_run = 0;
    end else if (out_run_ff > 999) begin
      nxt_out_run = out_run_ff;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ff <= '0;
      out_run_ff <= 0;
    end else begin
      seen_ff <= nxt_seen;
      out_run_ff <= nxt_out_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence run_low_s;
    !run_ss_on [*7];
  endsequence
  sequence steady_code_s;
    (boot_done && stop_clock_request_n && !deeper_sleep_select && $stable(voltage_code)) [*7];
  endsequence
  sequence out_start_s;
    $fell(vout_in_window) && power_good_out_oe_n && run_ss_on ##1 (run_ss_on && !vout_in_window) [*6];
  endsequence
  open_drain_a: assert property (power_good_out_o == 1'b0)
    else $error("power good pin drives high");
  run_low_pg_a: assert property (run_low_s |-> !power_good_out_oe_n)
    else $error("power good not pulled low with run low");
  run_low_off_a: assert property (run_low_s |-> !regulator_enable && !boot_done)
    else $error("regulator still on with run low");
  foldback_on_a: assert property ((run_ss_on && vout_below_70) [*7]
    |-> current_limit_active)
    else $error("current limit inactive");
  deeper_mode_a: assert property ((boot_done && deeper_sleep_select) [*7]
    |-> target_mode == MODE_DEEPER)
    else $error("deeper sleep mode not selected");
  deep_mode_a: assert property (
    (boot_done && !stop_clock_request_n && !deeper_sleep_select) [*7]
    |-> target_mode == MODE_DEEP)
    else $error("deep sleep mode not selected");
  code_target_a: assert property (steady_code_s
    |-> target_mv == VID_TOP_MV - {1'b0, voltage_code, 4'h0})
    else $error("code target wrong");
  blank_end_a: assert property (out_run_ff > BLANK_CYC + 8 |-> !power_good_out_oe_n)
    else $error("power good still released after blanking");
  fault_held_a: assert property (out_start_s |-> power_good_out_oe_n)
    else $error("fault reported before blanking time");
endmodule : supply_checker
bind supply_target_power_good_out_mask supply_checker #(.BLANK_CYC(BLANK_CYC)) chk_u (.*);
`default_nettype wire

// [verif/pm_partner.sv]
`default_nettype none
module pm_partner (
  input wire logic sys_clk,
  input wire logic chip_en,
  input wire logic pullup_en,
  input wire logic power_good_out_o,
  input wire logic power_good_out_oe_n,
  output logic power_good_out_i,
  output logic chipset_power_good,
  output logic latch_defeat
);
  timeunit 1ns;
  timeprecision 1ps;
  // External pull-up resistor on the open-drain line
  assign power_good_out_i = power_good_out_oe_n ? 1'b1 : power_good_out_o;
  assign latch_defeat = pullup_en;
  // Chipset reports good one cycle after seeing the pin high
  always @(posedge sys_clk) begin
    chipset_power_good <= chip_en & power_good_out_i;
  end
endmodule : pm_partner
`default_nettype wire

// [verif/supply_target_power_good_out_mask_bench.sv]
`default_nettype none
module supply_target_power_good_out_mask_bench import supply_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = '0, rst_n = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, target_mode;
  logic [5:0] voltage_code = '0;
  logic stop_clock_request_n = '1, deeper_sleep_select = '0, run_ss_on = '0;
  logic run_ss_armed = '0, vout_in_window = '1, vout_below_70 = '0, chip_en = '0;
  logic pullup_en = '0, chipset_power_good, latch_defeat, power_good_out_i;
  logic power_good_out_o, power_good_out_oe_n, boot_done, regulator_enable;
  logic current_limit_active, irq;
  logic [10:0] target_mv, tgt;
  logic [33:0] exp_q[$];
  int fail_count = 0, cmp_count = 0, seed = 76788;
  supply_target_power_good_out_mask #(.BLANK_CYC(20), .SW_DIV(4), .SC_START_CYC(30), .SC_RUN_CYC(60))
    dut_u (.*);
  pm_partner pm_u (.*);
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      step(1);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("write resp", s_axi_bresp, 2'h0);
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      step(1);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask : rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // Read data watcher takes the oldest note on every read handshake
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read data", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  initial begin
    step(20000);
    fail_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(4);
    rst_n <= 1'b1;
    step(1);
    rd(REG_MASK, MASK_RST);
    rd(REG_DEEP_OFS, DEEP_OFS_RST);
    rd(REG_BOOT_MV, BOOT_MV_RST);
    rd(REG_DEEPER_MV, DEEPER_MV_RST);
    rd(8'h1c, {2'b10, 32'h0000_0000});
    run_ss_on <= 1'b1;
    chip_en <= 1'b1;
    step(20);
    chk("pg before arming", power_good_out_oe_n, 1'b0);
    run_ss_armed <= 1'b1;
    step(50);
    chk("boot early", boot_done, 1'b0);
    for (int i = 0; i < 200 && boot_done !== 1'b1; i++) step(1);
    chk("boot done", boot_done, 1'b1);
    chk("pg released", power_good_out_oe_n, 1'b1);
    rd(REG_IRQ, 32'h0000_0004);
    for (int i = 0; i < 6; i++) begin
      voltage_code <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      step(10);
      tgt = VID_TOP_MV - VID_STEP_MV * voltage_code;
      chk("code target", target_mv, tgt);
    end
    stop_clock_request_n <= 1'b0;
    step(10);
    chk("deep mode", target_mode, MODE_DEEP);
    chk("deep lower", target_mv < tgt, 1'b1);
    deeper_sleep_select <= 1'b1;
    step(10);
    chk("deeper mode", target_mode, MODE_DEEPER);
    chk("deeper mv", target_mv, DEEPER_MV_RST);
    wr(REG_DEEPER_MV, 32'h0000_0320);
    step(3);
    chk("deeper new mv", target_mv, 11'h320);
    rd(REG_TARGET, 32'h0000_0320);
    stop_clock_request_n <= 1'b1;
    deeper_sleep_select <= 1'b0;
    step(30);
    rd(REG_IRQ, 32'h0000_0008);
    wr(REG_MASK, 32'h0000_0001);
    vout_in_window <= 1'b0;
    voltage_code <= voltage_code ^ 6'h01;
    step(15);
    chk("pg masked", power_good_out_oe_n, 1'b1);
    step(25);
    chk("pg after blank", power_good_out_oe_n, 1'b0);
    chk("irq raised", irq, 1'b1);
    rd(REG_IRQ, 32'h0000_0001);
    step(2);
    chk("irq cleared", irq, 1'b0);
    vout_in_window <= 1'b1;
    step(10);
    vout_in_window <= 1'b0;
    repeat (5) begin
      voltage_code <= voltage_code + 6'h01;
      step(14);
    end
    chk("pg restarted", power_good_out_oe_n, 1'b1);
    step(40);
    chk("pg low after restarts", power_good_out_oe_n, 1'b0);
    rd(REG_IRQ, 32'h0000_0009);
    vout_in_window <= 1'b1;
    vout_below_70 <= 1'b1;
    step(45);
    chk("run latch later", regulator_enable, 1'b1);
    step(40);
    chk("latched off", regulator_enable, 1'b0);
    vout_below_70 <= 1'b0;
    step(10);
    chk("stays latched", regulator_enable, 1'b0);
    rd(REG_STATUS, 32'h0000_0116);
    rd(REG_IRQ, 32'h0000_0003);
    run_ss_on <= 1'b0;
    run_ss_armed <= 1'b0;
    step(8);
    chk("pg run low", power_good_out_oe_n, 1'b0);
    run_ss_on <= 1'b1;
    run_ss_armed <= 1'b1;
    vout_below_70 <= 1'b1;
    step(45);
    chk("start latch", regulator_enable, 1'b0);
    run_ss_on <= 1'b0;
    pullup_en <= 1'b1;
    step(8);
    run_ss_on <= 1'b1;
    step(100);
    chk("defeated", regulator_enable, 1'b1);
    chk("limit on", current_limit_active, 1'b1);
    conclude();
  end
endmodule : supply_target_power_good_out_mask_bench
`default_nettype wire
